/* design/mph_fifo.sv */
`timescale 1ns/1ps
module mph_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 32
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic flush_i,
	// Fill side
	mph_stream_if.snk in_s,
	// Drain side
	mph_stream_if.src out_s
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;
	assign in_s.ready = (cnt_r != (AW+1)'(DEPTH)) && !flush_i;
	assign out_s.valid = cnt_r != '0;
	assign out_s.data = mem_r[rp_r];
	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (flush_i) begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
		end else begin
			if (push) wp_nxt = wp_r + AW'(1);
			if (pop) rp_nxt = rp_r + AW'(1);
			if (push && !pop) cnt_nxt = cnt_r + (AW+1)'(1);
			if (pop && !push) cnt_nxt = cnt_r - (AW+1)'(1);
		end
	end
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// Storage
	always_ff @(posedge clock_i) begin
		if (push) mem_r[wp_r] <= in_s.data;
	end
endmodule

/* design/mph_host_port.sv */
`timescale 1ns/1ps
module mph_host_port (
	// Clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// Host pins
	input wire logic init_hold_n_i,
	input wire logic host_style_pick_i,
	input wire logic chip_sel_n_i,
	input wire logic data_instruction_select_i,
	input wire logic rd_enable_i,
	input wire logic wr_dir_i,
	input wire logic [mph_pkg::MPH_DATA_W-1:0] bus_lines_i,
	output logic [mph_pkg::MPH_DATA_W-1:0] bus_lines_o,
	output logic bus_lines_oe_o,
	// Core side: received words
	output logic rx_valid_o,
	output logic rx_is_data_o,
	output logic [mph_pkg::MPH_DATA_W-1:0] rx_byte_o,
	input wire logic rx_ready_i,
	// Core side: read data
	input wire logic [mph_pkg::MPH_DATA_W-1:0] rd_data_i,
	input wire logic [mph_pkg::MPH_DATA_W-1:0] rd_status_i,
	output logic rd_taken_o,
	// State
	output logic init_busy_o,
	output logic overflow_o
);
	import mph_pkg::*;
	typedef enum logic [2:0] {
		MPH_IDLE = 3'h1,
		MPH_WRITE = 3'h2,
		MPH_READ = 3'h4
	} mph_state_t;

	// Two-flop synchronisers, one per pin
	localparam int unsigned NS = MPH_DATA_W + 6;
	logic [NS-1:0] pin_raw, s1_r, s2_r;
	// Reset value: pins idle, except the reset pin, which reads as held
	localparam logic [NS-1:0] SYNC_IDLE = {1'h0, {(NS-1){1'h1}}};
	assign pin_raw = {init_hold_n_i, bus_lines_i, host_style_pick_i,
		chip_sel_n_i, data_instruction_select_i, rd_enable_i, wr_dir_i};
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i) begin
					s1_r[gi] <= SYNC_IDLE[gi];
					s2_r[gi] <= SYNC_IDLE[gi];
				end else begin
					s1_r[gi] <= pin_raw[gi];
					s2_r[gi] <= s1_r[gi];
				end
			end
		end
	endgenerate
	logic [MPH_DATA_W-1:0] bus_s;
	logic init_n_s, style_s, cs_n_s, dis_s, rd_s, wr_s;
	assign {init_n_s, bus_s, style_s, cs_n_s, dis_s, rd_s, wr_s} = s2_r;

	// Access decode
	logic sel, rd_act, wr_act;
	always_comb begin
		sel = !cs_n_s && init_n_s;
		if (style_s == MPH_STYLE_68) begin
			rd_act = sel && rd_s && (wr_s == MPH_RW_READ);
			wr_act = sel && rd_s && (wr_s != MPH_RW_READ);
		end else begin
			rd_act = sel && !rd_s;
			wr_act = sel && !wr_s;
		end
	end

	mph_stream_if fin ();
	mph_stream_if fout ();
	mph_fifo #(.WIDTH(MPH_WORD_W), .DEPTH(MPH_FIFO_DEPTH)) u_fifo (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.flush_i(!init_n_s),
		.in_s(fin),
		.out_s(fout)
	);

	mph_state_t st_r, st_nxt;
	logic [MPH_DATA_W-1:0] wbyte_r, wbyte_nxt;
	logic wdis_r, wdis_nxt, push;
	logic ovf_r, ovf_nxt, busy_r, busy_nxt;

	// Transfer control: write capture, commit and overflow
	always_comb begin
		st_nxt = st_r;
		wbyte_nxt = wbyte_r;
		wdis_nxt = wdis_r;
		push = 1'h0;
		ovf_nxt = ovf_r;
		busy_nxt = !init_n_s;
		unique case (st_r)
			MPH_IDLE: begin
				if (rd_act) begin
					st_nxt = MPH_READ;
				end else if (wr_act) begin
					st_nxt = MPH_WRITE;
					wbyte_nxt = bus_s;
					wdis_nxt = dis_s;
				end
			end
			MPH_WRITE: begin
				if (wr_act) begin
					wbyte_nxt = bus_s;
					wdis_nxt = dis_s;
				end else begin
					// Strobe ended: commit the sampled byte
					st_nxt = MPH_IDLE;
					push = 1'h1;
				end
			end
			MPH_READ: begin
				if (!rd_act) st_nxt = MPH_IDLE;
			end
		endcase
		// A full buffer drops the word and leaves a sticky mark
		if (push && !fin.ready) ovf_nxt = 1'h1;
		if (!init_n_s) begin
			st_nxt = MPH_IDLE;
			ovf_nxt = 1'h0;
			push = 1'h0;
		end
	end
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= MPH_IDLE;
			wbyte_r <= MPH_ZERO_BYTE;
			wdis_r <= 1'h0;
			ovf_r <= 1'h0;
			busy_r <= 1'h1;
		end else begin
			st_r <= st_nxt;
			wbyte_r <= wbyte_nxt;
			wdis_r <= wdis_nxt;
			ovf_r <= ovf_nxt;
			busy_r <= busy_nxt;
		end
	end

	// Read drive: bus value, output enable and data-read pulse
	logic [MPH_DATA_W-1:0] dout_r, dout_nxt;
	logic oe_r, oe_nxt, taken_r, taken_nxt;
	always_comb begin
		dout_nxt = dout_r;
		oe_nxt = 1'h0;
		taken_nxt = 1'h0;
		if (st_r == MPH_IDLE && rd_act) begin
			oe_nxt = 1'h1;
			taken_nxt = (dis_s == MPH_DIS_DATA);
			dout_nxt = (dis_s == MPH_DIS_DATA) ? rd_data_i : rd_status_i;
		end else if (st_r == MPH_READ) begin
			oe_nxt = rd_act;
		end
		if (!init_n_s) oe_nxt = 1'h0;
	end
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dout_r <= MPH_ZERO_BYTE;
			oe_r <= 1'h0;
			taken_r <= 1'h0;
		end else begin
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
			taken_r <= taken_nxt;
		end
	end

	// Received word stage towards the core
	logic rxv_r, rxv_nxt, rxd_r, rxd_nxt;
	logic [MPH_DATA_W-1:0] rxb_r, rxb_nxt;
	assign fin.valid = push;
	assign fin.data = {wdis_r, wbyte_r};
	assign fout.ready = !rxv_r || rx_ready_i;
	always_comb begin
		rxv_nxt = rxv_r;
		rxd_nxt = rxd_r;
		rxb_nxt = rxb_r;
		if (!init_n_s) begin
			rxv_nxt = 1'h0;
		end else if (fout.ready) begin
			rxv_nxt = fout.valid;
			rxd_nxt = fout.data[MPH_DIS_BIT];
			rxb_nxt = fout.data[MPH_DATA_W-1:0];
		end
	end
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rxv_r <= 1'h0;
			rxd_r <= 1'h0;
			rxb_r <= MPH_ZERO_BYTE;
		end else begin
			rxv_r <= rxv_nxt;
			rxd_r <= rxd_nxt;
			rxb_r <= rxb_nxt;
		end
	end
	assign bus_lines_o = dout_r;
	assign bus_lines_oe_o = oe_r;
	assign rx_valid_o = rxv_r;
	assign rx_is_data_o = rxd_r;
	assign rx_byte_o = rxb_r;
	assign rd_taken_o = taken_r;
	assign init_busy_o = busy_r;
	assign overflow_o = ovf_r;
endmodule

/* dv/mph_host_model.sv */
`timescale 1ns/1ps
module mph_host_model (
	// Host side pins
	input wire logic clock_i,
	input wire logic sty_i,
	input wire logic [7:0] dq_i,
	output logic cs_n_o,
	output logic dis_o,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] dq_o
);
	// No serial pins exist, so none can float
	initial {cs_n_o, dis_o, rd_o, wr_o, dq_o} = 12'hb00;
	task automatic xfer(input logic r, a, sel, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clock_i) #1 {cs_n_o, dis_o, dq_o} = {!sel, a, d};
		rd_o = !sty_i;
		wr_o = sty_i ? r : 1'h1;
		@(posedge clock_i) #1 rd_o = sty_i ? 1'h1 : !r;
		wr_o = wr_o & (sty_i | r);
		repeat (5) @(posedge clock_i);
		q = dq_i;
		#1 {rd_o, wr_o} = {!sty_i, 1'h1};
		@(posedge clock_i) #1 {cs_n_o, dq_o} = {1'h1, ~d};
		repeat (2) @(posedge clock_i);
	endtask
endmodule

/* dv/mph_host_port_props.sv */
`timescale 1ns/1ps
module mph_host_port_props (
	// Watched pins
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic init_hold_n_i,
	input wire logic host_style_pick_i,
	input wire logic chip_sel_n_i,
	input wire logic rd_enable_i,
	input wire logic wr_dir_i,
	input wire logic bus_lines_oe_o,
	input wire logic rd_taken_o,
	input wire logic init_busy_o,
	input wire logic overflow_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	wire s = host_style_pick_i;
	wire on = !chip_sel_n_i && init_hold_n_i;
	wire oe = bus_lines_oe_o;
	wire r8 = on && !s && !rd_enable_i;
	wire r6 = on && s && rd_enable_i && wr_dir_i;
	cs_idle_a: assert property (chip_sel_n_i[*5] |-> !oe)
		else $error("driven unselected");
	busy_hold_a: assert property (!init_hold_n_i[*4] |-> init_busy_o)
		else $error("busy low");
	ovf_clear_a: assert property (!init_hold_n_i[*5] |-> !overflow_o)
		else $error("overflow kept");
	rd80_on_a: assert property (r8[*5] |-> oe)
		else $error("no drive");
	rd68_on_a: assert property (r6[*5] |-> oe)
		else $error("no drive");
	idle80_a: assert property ((!s && rd_enable_i)[*5] |-> !oe)
		else $error("driven idle");
	wr68_off_a: assert property ((s && !wr_dir_i)[*5] |-> !oe)
		else $error("driven on write");
	taken_oe_a: assert property (rd_taken_o |-> oe)
		else $error("taken undriven");
	cover property (rd_taken_o);
	cover property (overflow_o);
	cover property (r6 && oe);
endmodule
bind mph_host_port mph_host_port_props i_props (.*);

/* dv/mph_host_port_tb.sv */
`timescale 1ns/1ps
module mph_host_port_tb;
	logic clock_i = 0, resetn_i = 0, init_hold_n_i = 0, skip = 0;
	logic host_style_pick_i = 0, rx_ready_i = 0;
	logic [7:0] rd_data_i = 0, rd_status_i = 0, bus_lines_o, rx_byte_o, mo;
	logic chip_sel_n_i, data_instruction_select_i, rd_enable_i, wr_dir_i;
	logic bus_lines_oe_o, rx_valid_o, rx_is_data_o, rd_taken_o;
	logic init_busy_o, overflow_o;
	wire logic [7:0] bus_lines_i = bus_lines_oe_o ? bus_lines_o : mo;
	int mismatches = 0, compares = 0, cnt = 0, tk = 0;
	logic [8:0] eq[$];
	always #5 clock_i = ~clock_i;
	mph_host_port i_mph_host_port (.*);
	mph_host_model i_mph_host_model (.clock_i, .sty_i(host_style_pick_i),
		.dq_i(bus_lines_i), .cs_n_o(chip_sel_n_i), .rd_o(rd_enable_i),
		.dis_o(data_instruction_select_i), .wr_o(wr_dir_i), .dq_o(mo));
	task automatic chk(input logic [8:0] got, exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic [8:0] exp_rd(input logic a, input logic [7:0] d, s);
		return {1'h0, a ? d : s};
	endfunction
	always @(posedge clock_i) begin
		if (rd_taken_o === 1'h1) tk++;
		if (rx_valid_o === 1'h1 && rx_ready_i) begin
			cnt++;
			if (!skip) chk({rx_is_data_o, rx_byte_o}, eq.pop_front());
		end
	end
	task automatic op(input logic sel);
		logic r, a;
		logic [7:0] d, q;
		int n;
		@(posedge clock_i) #1 {r, a, d, rd_data_i, rd_status_i} = 26'($urandom);
		r &= sel && !skip;
		rx_ready_i = !skip && 1'($urandom);
		if (!r && sel && !skip) eq.push_back({a, d});
		n = tk;
		i_mph_host_model.xfer(r, a, sel, d, q);
		if (r) chk({1'h0, q}, exp_rd(a, rd_data_i, rd_status_i));
		chk(9'(tk - n), 9'(r && a));
	endtask
	initial begin
		void'($urandom(32'hd745));
		repeat (10) @(posedge clock_i);
		#1 resetn_i = 1;
		repeat (5) @(posedge clock_i);
		chk(9'(init_busy_o), 9'h1);
		#1 init_hold_n_i = 1;
		repeat (5) @(posedge clock_i);
		chk(9'(init_busy_o), 9'h0);
		repeat (2) begin
			op(1'h0);
			repeat (30) op(1'h1);
			#1 host_style_pick_i = !host_style_pick_i;
		end
		rx_ready_i = 1;
		repeat (40) @(posedge clock_i);
		chk(9'(eq.size()), 9'h0);
		#1 skip = 1;
		cnt = 0;
		repeat (36) op(1'h1);
		chk(9'(overflow_o), 9'h1);
		#1 rx_ready_i = 1;
		repeat (60) @(posedge clock_i);
		chk(9'(cnt), 9'(mph_pkg::MPH_FIFO_DEPTH + 1));
		#1 init_hold_n_i = 0;
		repeat (5) @(posedge clock_i);
		chk(9'(overflow_o), 9'h0);
		report_and_stop();
	end
endmodule

/* include/mph_pkg.sv */
package mph_pkg;
	localparam int unsigned MPH_DATA_W = 8;
	localparam int unsigned MPH_FIFO_DEPTH = 32;
	localparam int unsigned MPH_WORD_W = MPH_DATA_W + 1;
	localparam logic MPH_STYLE_68 = 1'h1;
	localparam logic MPH_STYLE_80 = 1'h0;
	localparam logic MPH_DIS_DATA = 1'h1;
	localparam logic MPH_RW_READ = 1'h1;
	localparam int unsigned MPH_DIS_BIT = 8;
	localparam logic [7:0] MPH_ZERO_BYTE = 8'h00;
endpackage

/* include/mph_stream_if.sv */
`timescale 1ns/1ps
interface mph_stream_if;
	logic valid;
	logic ready;
	logic [8:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
